//--- src/uhbi_host_port.sv
// Separate-strobe parallel host port of a UART with its two byte FIFOs
//
// Contract
// - The port works in separate-strobe mode only while the bus mode select input is high.
// - The host's 3-bit register index chooses which internal register a cycle reaches.
// - Bytes move over an 8-bit two-way data bus, driven by the port on reads and by the host on writes.
// - The falling edge of the low read strobe starts a read that fetches the indexed byte onto the bus.
// - Either read strobe starts a read, the two differing only in polarity.
// - A write strobe's leading edge opens a write and its trailing edge stores the bus byte at the index.
// - Either write strobe starts a write, the two differing only in polarity.
// - The port answers only while the first two selects are high and the third is low.
// - Transmit and receive bytes are held in separate FIFOs of 32 bytes each.
// - The leading edge of the low address strobe latches selects and index, and a tied-low strobe still captures.
`timescale 1ns/10ps

module uhbi_host_port
	import uhbi_pkg::*;
(
	input wire logic CLK_I, // 200 MHz clock
	input wire logic RST_N_I, // Asynchronous reset, active low
	input wire logic MODE_SEL_I, // Bus mode select pin
	input wire logic [2:0] REGISTER_INDEX_I, // Register index pins
	input wire logic [7:0] DATA_I, // Data bus, level seen on the pins
	output logic [7:0] DATA_O, // Data bus, value driven on reads
	output logic DATA_OE_O, // Data bus output enable, high drives
	input wire logic READ_STROBE_LOW_N_I, // Read strobe, active low
	input wire logic READ_STROBE_HIGH_I, // Read strobe, active high
	input wire logic WRITE_STROBE_LOW_N_I, // Write strobe, active low
	input wire logic WRITE_STROBE_HIGH_I, // Write strobe, active high
	input wire logic SELECT_FIRST_HIGH_I, // First select, active high
	input wire logic SELECT_SECOND_HIGH_I, // Second select, active high
	input wire logic SELECT_THIRD_LOW_N_I, // Third select, active low
	input wire logic ADDRESS_LATCH_STROBE_N_I, // Address latch strobe, active low
	output logic [2:0] REG_INDEX_O, // Latched index toward the register file
	output logic REG_RD_O, // Register fetch pulse, data taken same cycle
	input wire logic [7:0] REG_RD_DATA_I, // Register byte for a fetch
	output logic REG_WR_O, // Register store pulse
	output logic [7:0] REG_WDATA_O, // Byte for a store
	output logic [7:0] TX_DATA_O, // Transmit FIFO head byte
	output logic TX_VALID_O, // Transmit FIFO not empty
	input wire logic TX_READY_I, // Serialiser takes the head byte
	output logic TX_OVERRUN_O, // Pulse: host wrote into a full transmit FIFO
	input wire logic [7:0] RX_DATA_I, // Received byte
	input wire logic RX_VALID_I, // Received byte offered
	output logic RX_READY_O // Receive FIFO has room
);

	// ****************************************
	// State
	// ****************************************
	uhbi_regs_t s;
	uhbi_regs_t next_s;
	uhbi_pins_t p;
	logic rd_on;
	logic wr_on;
	logic cap;
	logic [2:0] cur_idx;
	logic cur_sel;
	logic tx_full;
	logic tx_empty;
	logic rx_full;
	logic rx_empty;
	logic reg_rd;

	assign p = s.pins;

	// FIFO occupancy from the extra wrap bit of each pointer
	assign tx_empty = (s.tx_wp == s.tx_rp);
	assign tx_full = (s.tx_wp[UHBI_PTR_W-2:0] == s.tx_rp[UHBI_PTR_W-2:0]) && !tx_empty;
	assign rx_empty = (s.rx_wp == s.rx_rp);
	assign rx_full = (s.rx_wp[UHBI_PTR_W-2:0] == s.rx_rp[UHBI_PTR_W-2:0]) && !rx_empty;

	// ****************************************
	// Next-state logic
	// ****************************************
	// Pins are two flops late; strobes and data share that delay, so their relative order holds
	always_comb begin
		next_s = s;
		reg_rd = 1'b0;
		next_s.sync1 = '{
			mode_sel: MODE_SEL_I,
			read_strobe_low_n: READ_STROBE_LOW_N_I,
			read_strobe_high: READ_STROBE_HIGH_I,
			write_strobe_low_n: WRITE_STROBE_LOW_N_I,
			write_strobe_high: WRITE_STROBE_HIGH_I,
			select_first_high: SELECT_FIRST_HIGH_I,
			select_second_high: SELECT_SECOND_HIGH_I,
			select_third_low_n: SELECT_THIRD_LOW_N_I,
			address_latch_strobe_n: ADDRESS_LATCH_STROBE_N_I,
			register_index: REGISTER_INDEX_I,
			data: DATA_I
		};
		next_s.pins = s.sync1;
		next_s.as_prev = p.address_latch_strobe_n;
		next_s.reg_wr = 1'b0;
		next_s.tx_ovf = 1'b0;

		// Strobes count only in separate-strobe mode
		rd_on = p.mode_sel && (!p.read_strobe_low_n || p.read_strobe_high);
		wr_on = p.mode_sel && (!p.write_strobe_low_n || p.write_strobe_high);

		// Capture on the strobe's falling edge, and while it sits low between cycles so a tied strobe works
		cap = !p.address_latch_strobe_n && (s.as_prev || (s.st == UHBI_ST_IDLE));
		cur_idx = cap ? p.register_index : s.idx;
		cur_sel = cap ? (p.select_first_high && p.select_second_high && !p.select_third_low_n) : s.sel;
		next_s.idx = cur_idx;
		next_s.sel = cur_sel;

		case (s.st)
			UHBI_ST_IDLE: begin
				if (cur_sel && rd_on) begin
					// Fetch at the leading edge so the byte is ready well before the host samples
					next_s.st = UHBI_ST_READ;
					if (cur_idx == UHBI_IDX_HOLDING) begin
						if (!rx_empty) begin
							next_s.rd_data = s.rx_mem[s.rx_rp[UHBI_PTR_W-2:0]];
							next_s.rx_rp = s.rx_rp + UHBI_PTR_ONE;
						end else begin
							next_s.rd_data = UHBI_EMPTY_READ;
						end
					end else begin
						reg_rd = 1'b1;
						next_s.rd_data = REG_RD_DATA_I;
					end
				end else if (cur_sel && wr_on) begin
					next_s.st = UHBI_ST_WRITE;
				end
			end
			UHBI_ST_READ: begin
				if (!rd_on) begin
					next_s.st = UHBI_ST_IDLE;
				end
			end
			UHBI_ST_WRITE: begin
				// Store on the trailing edge, when the host's byte has had the whole strobe to settle
				if (!wr_on) begin
					next_s.st = UHBI_ST_IDLE;
					if (s.idx == UHBI_IDX_HOLDING) begin
						if (!tx_full) begin
							next_s.tx_mem[s.tx_wp[UHBI_PTR_W-2:0]] = p.data;
							next_s.tx_wp = s.tx_wp + UHBI_PTR_ONE;
						end else begin
							next_s.tx_ovf = 1'b1;
						end
					end else begin
						next_s.reg_wr = 1'b1;
						next_s.wdata = p.data;
					end
				end
			end
			default: begin
				next_s.st = UHBI_ST_IDLE;
			end
		endcase

		// Serial side of the FIFOs; these pointers are never touched by the host path
		if (TX_READY_I && !tx_empty) begin
			next_s.tx_rp = s.tx_rp + UHBI_PTR_ONE;
		end
		if (RX_VALID_I && !rx_full) begin
			next_s.rx_mem[s.rx_wp[UHBI_PTR_W-2:0]] = RX_DATA_I;
			next_s.rx_wp = s.rx_wp + UHBI_PTR_ONE;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	// Single state register; FIFO storage resets too so reads are never unknown
	always_ff @(posedge CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			s <= '{
				sync1: UHBI_PINS_IDLE,
				pins: UHBI_PINS_IDLE,
				as_prev: 1'b1,
				idx: UHBI_IDX_RESET,
				sel: 1'b0,
				st: UHBI_ST_IDLE,
				rd_data: UHBI_BYTE_RESET,
				reg_wr: 1'b0,
				wdata: UHBI_BYTE_RESET,
				tx_ovf: 1'b0,
				tx_mem: '0,
				tx_wp: UHBI_PTR_RESET,
				tx_rp: UHBI_PTR_RESET,
				rx_mem: '0,
				rx_wp: UHBI_PTR_RESET,
				rx_rp: UHBI_PTR_RESET
			};
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// Bus released the cycle the strobe or the latched select drops away
	assign DATA_OE_O = (s.st == UHBI_ST_READ) && rd_on && s.sel;
	assign DATA_O = s.rd_data;
	assign REG_INDEX_O = s.idx;
	assign REG_RD_O = reg_rd;
	assign REG_WR_O = s.reg_wr;
	assign REG_WDATA_O = s.wdata;
	assign TX_DATA_O = s.tx_mem[s.tx_rp[UHBI_PTR_W-2:0]];
	assign TX_VALID_O = !tx_empty;
	assign TX_OVERRUN_O = s.tx_ovf;
	assign RX_READY_O = !rx_full;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	mode_gate_a: assert property (!p.mode_sel && s.st == UHBI_ST_IDLE |=> s.st == UHBI_ST_IDLE)
		else $error("cycle started with mode select low");
	index_fetch_a: assert property (reg_rd |=> s.rd_data == $past(REG_RD_DATA_I) && s.idx != UHBI_IDX_HOLDING)
		else $error("fetched byte or index wrong");
	bus_drive_a: assert property (DATA_OE_O |-> s.sel && s.st == UHBI_ST_READ && DATA_O == s.rd_data)
		else $error("bus driven outside a selected read");
	read_start_a: assert property (s.st == UHBI_ST_IDLE && cur_sel && p.mode_sel && !p.read_strobe_low_n
		|=> s.st == UHBI_ST_READ ##1 DATA_OE_O || !rd_on)
		else $error("low read strobe did not start a read");
	read_high_a: assert property (s.st == UHBI_ST_IDLE && cur_sel && p.mode_sel && p.read_strobe_high
		|=> s.st == UHBI_ST_READ)
		else $error("high read strobe did not start a read");
	write_commit_a: assert property (s.st == UHBI_ST_WRITE && !wr_on && s.idx != UHBI_IDX_HOLDING
		|=> REG_WR_O && REG_WDATA_O == $past(p.data) && s.st == UHBI_ST_IDLE)
		else $error("trailing write edge did not store");
	write_high_a: assert property (s.st == UHBI_ST_IDLE && cur_sel && !rd_on && p.mode_sel && p.write_strobe_high
		|=> s.st == UHBI_ST_WRITE)
		else $error("high write strobe did not start a write");
	unselected_a: assert property (s.st == UHBI_ST_IDLE && !cur_sel |=> s.st == UHBI_ST_IDLE)
		else $error("cycle started while deselected");
	fifo_bound_a: assert property ((6'(s.tx_wp - s.tx_rp) <= 6'(UHBI_FIFO_DEPTH))
		&& (6'(s.rx_wp - s.rx_rp) <= 6'(UHBI_FIFO_DEPTH)))
		else $error("FIFO holds more than its depth");
	addr_latch_a: assert property (s.as_prev && !p.address_latch_strobe_n |=> s.idx == $past(p.register_index))
		else $error("index not latched at address strobe edge");

endmodule : uhbi_host_port

//--- src/uhbi_pkg.sv
// Shared types and constants of the UART host bus interface
package uhbi_pkg;

	// ****************************************
	// Geometry
	// ****************************************
	localparam int unsigned UHBI_FIFO_DEPTH = 32;
	localparam int unsigned UHBI_PTR_W = 6;
	localparam logic [2:0] UHBI_IDX_HOLDING = 3'h0;
	localparam logic [7:0] UHBI_EMPTY_READ = 8'h00;
	localparam logic [5:0] UHBI_PTR_ONE = 6'h01;
	localparam logic [5:0] UHBI_PTR_RESET = 6'h00;
	localparam logic [2:0] UHBI_IDX_RESET = 3'h0;
	localparam logic [7:0] UHBI_BYTE_RESET = 8'h00;

	// ****************************************
	// Types
	// ****************************************
	// Host pins as sampled, one bundle per synchroniser stage
	typedef struct packed {
		logic mode_sel;
		logic read_strobe_low_n;
		logic read_strobe_high;
		logic write_strobe_low_n;
		logic write_strobe_high;
		logic select_first_high;
		logic select_second_high;
		logic select_third_low_n;
		logic address_latch_strobe_n;
		logic [2:0] register_index;
		logic [7:0] data;
	} uhbi_pins_t;

	// Bus cycle states, one-hot
	typedef enum logic [2:0] {
		UHBI_ST_IDLE = 3'h1,
		UHBI_ST_READ = 3'h2,
		UHBI_ST_WRITE = 3'h4
	} uhbi_state_t;

	typedef struct packed {
		uhbi_pins_t sync1;
		uhbi_pins_t pins;
		logic as_prev;
		logic [2:0] idx;
		logic sel;
		uhbi_state_t st;
		logic [7:0] rd_data;
		logic reg_wr;
		logic [7:0] wdata;
		logic tx_ovf;
		logic [UHBI_FIFO_DEPTH-1:0][7:0] tx_mem;
		logic [UHBI_PTR_W-1:0] tx_wp;
		logic [UHBI_PTR_W-1:0] tx_rp;
		logic [UHBI_FIFO_DEPTH-1:0][7:0] rx_mem;
		logic [UHBI_PTR_W-1:0] rx_wp;
		logic [UHBI_PTR_W-1:0] rx_rp;
	} uhbi_regs_t;

	// Pins at their idle levels: strobes and selects inactive
	localparam uhbi_pins_t UHBI_PINS_IDLE = '{
		mode_sel: 1'b0,
		read_strobe_low_n: 1'b1,
		read_strobe_high: 1'b0,
		write_strobe_low_n: 1'b1,
		write_strobe_high: 1'b0,
		select_first_high: 1'b0,
		select_second_high: 1'b0,
		select_third_low_n: 1'b1,
		address_latch_strobe_n: 1'b1,
		register_index: 3'h0,
		data: 8'h00
	};

endpackage : uhbi_pkg

//--- test/uhbi_host_model.sv
// Host processor model driving the separate-strobe pins of the port
`timescale 1ns/10ps

module uhbi_host_model
	import uhbi_pkg::*;
(
	input wire logic clk_i, // Bench clock
	input wire logic [7:0] bus_i, // Resolved data bus
	output uhbi_pins_t pins_o, // Host-driven pins
	output logic drive_o // High while the host drives data
);
	// ****************************************
	// Idle pins
	// ****************************************
	// Address strobe tied low; selects stay inactive until a cycle sets them
	initial begin
		pins_o = UHBI_PINS_IDLE;
		pins_o.address_latch_strobe_n = 1'b0;
		drive_o = 1'b0;
	end

	// ****************************************
	// Bus cycles
	// ****************************************
	// One strobe cycle; cfg is {mode, first, second, third_n}, slow timing keeps clear of the minimum
	task automatic cycle(input logic wr, input logic pol, input logic [2:0] idx, input logic [3:0] cfg,
		input logic [7:0] d, output logic [7:0] q);
		@(posedge clk_i);
		#1;
		{pins_o.mode_sel, pins_o.select_first_high, pins_o.select_second_high, pins_o.select_third_low_n} = cfg;
		pins_o.register_index = idx;
		pins_o.data = d;
		drive_o = wr;
		repeat (2) @(posedge clk_i);
		#1;
		pins_o.write_strobe_high = wr & pol;
		pins_o.write_strobe_low_n = ~(wr & ~pol);
		pins_o.read_strobe_high = ~wr & pol;
		pins_o.read_strobe_low_n = ~(~wr & ~pol);
		repeat (6) @(posedge clk_i);
		q = bus_i;
		#1;
		pins_o.write_strobe_high = 1'b0;
		pins_o.write_strobe_low_n = 1'b1;
		pins_o.read_strobe_high = 1'b0;
		pins_o.read_strobe_low_n = 1'b1;
		// Data kept past the trailing edge so the store sees a settled byte
		repeat (5) @(posedge clk_i);
		#1;
		drive_o = 1'b0;
	endtask : cycle

	// Move the address strobe and index, then let three edges pass
	task automatic as_set(input logic [2:0] idx, input logic lvl);
		@(posedge clk_i);
		#1;
		pins_o.register_index = idx;
		pins_o.address_latch_strobe_n = lvl;
		repeat (3) @(posedge clk_i);
	endtask : as_set

endmodule : uhbi_host_model

//--- test/uhbi_host_port_test.sv
// Self-checking testbench of the separate-strobe host port
`timescale 1ns/10ps

module uhbi_host_port_test;
	import uhbi_pkg::*;

	// ****************************************
	// Signals
	// ****************************************
	logic CLK_I = 1'b0;
	logic RST_N_I = 1'b0;
	logic [7:0] DATA_O, TX_DATA_O, REG_WDATA_O, REG_RD_DATA_I = 8'h00, RX_DATA_I = 8'h00, bus, last_bus = 8'h00, q;
	logic [2:0] REG_INDEX_O, idx, wr_idx;
	logic [7:0] wr_dat;
	logic [2:0] rd_idx;
	logic [3:0] sel_cfg [4] = '{4'h6, 4'ha, 4'hc, 4'hf};
	logic DATA_OE_O, REG_RD_O, REG_WR_O, TX_VALID_O, TX_OVERRUN_O, RX_READY_O, drive;
	logic TX_READY_I = 1'b0, RX_VALID_I = 1'b0;
	uhbi_pins_t pins;
	logic [31:0] seed = 32'hbc75;
	int error_cnt = 0, n_tests = 0, cyc = 0, wr_cnt = 0, rd_cnt = 0, oe_cnt = 0, ovf_cnt = 0, w0, r0, o0;

	always #2.5 CLK_I = ~CLK_I;

	// Undriven bus shows a changing pattern, never a held value
	assign bus = DATA_OE_O ? DATA_O : (drive ? pins.data : ~last_bus);

	uhbi_host_model u_uhbi_host_model (.clk_i(CLK_I), .bus_i(bus), .pins_o(pins), .drive_o(drive));

	uhbi_host_port u_uhbi_host_port (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .MODE_SEL_I(pins.mode_sel),
		.REGISTER_INDEX_I(pins.register_index), .DATA_I(bus), .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O),
		.READ_STROBE_LOW_N_I(pins.read_strobe_low_n), .READ_STROBE_HIGH_I(pins.read_strobe_high),
		.WRITE_STROBE_LOW_N_I(pins.write_strobe_low_n), .WRITE_STROBE_HIGH_I(pins.write_strobe_high),
		.SELECT_FIRST_HIGH_I(pins.select_first_high), .SELECT_SECOND_HIGH_I(pins.select_second_high),
		.SELECT_THIRD_LOW_N_I(pins.select_third_low_n), .ADDRESS_LATCH_STROBE_N_I(pins.address_latch_strobe_n),
		.REG_INDEX_O(REG_INDEX_O), .REG_RD_O(REG_RD_O), .REG_RD_DATA_I(REG_RD_DATA_I), .REG_WR_O(REG_WR_O),
		.REG_WDATA_O(REG_WDATA_O), .TX_DATA_O(TX_DATA_O), .TX_VALID_O(TX_VALID_O), .TX_READY_I(TX_READY_I),
		.TX_OVERRUN_O(TX_OVERRUN_O), .RX_DATA_I(RX_DATA_I), .RX_VALID_I(RX_VALID_I), .RX_READY_O(RX_READY_O));

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up

	// Monitor of pulses; also the hang limit, far above the expected run
	always @(posedge CLK_I) begin
		last_bus <= bus;
		cyc++;
		if (REG_WR_O === 1'b1) begin
			wr_cnt++;
			wr_idx = REG_INDEX_O;
			wr_dat = REG_WDATA_O;
		end
		if (REG_RD_O === 1'b1) begin
			rd_cnt++;
			rd_idx = REG_INDEX_O;
		end
		if (DATA_OE_O === 1'b1) oe_cnt++;
		if (TX_OVERRUN_O === 1'b1) ovf_cnt++;
		if (cyc == 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		repeat (8) @(posedge CLK_I);
		#1 RST_N_I = 1'b1;
		// Out of reset: transmit FIFO empty, receive FIFO open, bus released
		check("tx valid", 8'h00, {7'h00, TX_VALID_O});
		check("rx ready", 8'h01, {7'h00, RX_READY_O});
		check("bus enable", 8'h00, {7'h00, DATA_OE_O});
		// Random register writes and reads, both strobe polarities
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			idx = (seed[2:0] == 3'h0) ? 3'h1 : seed[2:0];
			w0 = wr_cnt;
			u_uhbi_host_model.cycle(1'b1, seed[16], idx, 4'he, seed[15:8], q);
			check("write count", 8'h01, 8'(wr_cnt - w0));
			check("write index", {5'h00, idx}, {5'h00, wr_idx});
			check("write data", seed[15:8], wr_dat);
			REG_RD_DATA_I = seed[31:24];
			r0 = rd_cnt;
			o0 = oe_cnt;
			u_uhbi_host_model.cycle(1'b0, seed[17], idx, 4'he, 8'h00, q);
			check("read data", seed[31:24], q);
			check("read fetch", 8'h01, 8'(rd_cnt - r0));
			check("read index", {5'h00, idx}, {5'h00, rd_idx});
			// Strobe stands six edges; the bus follows three edges late and lets go two edges after release
			check("drive cycles", 8'h05, 8'(oe_cnt - o0));
		end
		$display("test registers done");
		// Mode low, then each select inactive in turn: no answer at all
		foreach (sel_cfg[k]) begin
			w0 = wr_cnt;
			r0 = rd_cnt;
			o0 = oe_cnt;
			u_uhbi_host_model.cycle(1'b1, k[0], 3'h3, sel_cfg[k], 8'h5a, q);
			u_uhbi_host_model.cycle(1'b0, k[1], 3'h3, sel_cfg[k], 8'h00, q);
			check("ignored cycles", 8'h00, 8'((wr_cnt - w0) + (rd_cnt - r0) + (oe_cnt - o0)));
		end
		$display("test selection done");
		// Fill the transmit FIFO past full, then drain it in order
		for (int i = 0; i < 33; i++) u_uhbi_host_model.cycle(1'b1, 1'b0, 3'h0, 4'he, 8'h30 + 8'(i), q);
		check("overrun pulses", 8'h01, 8'(ovf_cnt));
		for (int i = 0; i < 32; i++) begin
			check("tx byte", 8'h30 + 8'(i), TX_DATA_O);
			TX_READY_I = 1'b1;
			@(posedge CLK_I);
			#1 TX_READY_I = 1'b0;
			@(posedge CLK_I);
			#1;
		end
		check("tx empty", 8'h00, {7'h00, TX_VALID_O});
		$display("test transmit done");
		// Fill the receive FIFO until it refuses, read it back, then read it empty
		for (int i = 0; i < 32; i++) begin
			RX_DATA_I = 8'ha0 + 8'(i);
			RX_VALID_I = 1'b1;
			@(posedge CLK_I);
			#1;
		end
		RX_VALID_I = 1'b0;
		check("rx full", 8'h00, {7'h00, RX_READY_O});
		for (int i = 0; i < 33; i++) begin
			u_uhbi_host_model.cycle(1'b0, i[0], 3'h0, 4'he, 8'h00, q);
			check("rx byte", (i < 32) ? 8'ha0 + 8'(i) : UHBI_EMPTY_READ, q);
		end
		$display("test receive done");
		// Address strobe captures index 5; the later index on the pins is ignored
		u_uhbi_host_model.as_set(3'h5, 1'b1);
		u_uhbi_host_model.as_set(3'h5, 1'b0);
		u_uhbi_host_model.as_set(3'h5, 1'b1);
		u_uhbi_host_model.cycle(1'b1, 1'b1, 3'h2, 4'he, 8'h77, q);
		check("latched index", 8'h05, {5'h00, wr_idx});
		u_uhbi_host_model.as_set(3'h2, 1'b0);
		$display("test address strobe done");
		wrap_up();
	end

endmodule : uhbi_host_port_test
